// [design/acsp_pkg.sv]
// ============================================================
// Codec stream port constants
package acsp_pkg;
   // ============================================================
   // Byte bus and FIFO word layout
   localparam int BYTE_W = 8;
   localparam int WORD_W = 11;
   localparam int FIFO_DEPTH = 8;
   localparam int W_START = 8;
   // Transmit words carry the end marker here, receive words the CRC fault
   localparam int W_END = 9;
   localparam int W_CRC = 9;
   localparam int W_SEQ = 10;

   // ============================================================
   // Header quadlet and timestamp fields
   localparam int QUAD_W = 32;
   localparam int SYT_W = 16;
   localparam int SYT_CYC_LSB = 12;
   localparam int SYT_CYC_W = 4;
   localparam int BUS_CYCLE_US = 125;
   localparam int SYT_ADVANCE_CYCLES = 3;
   localparam logic [SYT_CYC_W-1:0] SYT_ADVANCE =
      SYT_CYC_W'(SYT_ADVANCE_CYCLES);
endpackage : acsp_pkg

// [design/acsp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Two-flop level synchroniser
module acsp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;

   // No reset: it also carries the reset itself into the link domain
   always_ff @(posedge clk) begin
      meta <= din;
      dout <= meta;
   end
endmodule : acsp_sync
`default_nettype wire

// [design/acsp_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Dual-clock FIFO with gray pointers; DEPTH a power of two, 4 or more
module acsp_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   input wire logic wr_clk,
   input wire logic wr_rst,
   input wire logic wr_valid,
   input wire logic [WIDTH-1:0] wr_data,
   output logic wr_ready,
   input wire logic rd_clk,
   input wire logic rd_rst,
   output logic rd_valid,
   output logic [WIDTH-1:0] rd_data,
   input wire logic rd_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wbin, wgray, rbin, rgray;
   logic [AW:0] wq_rgray, rq_wgray;
   logic [AW:0] next_wbin, next_wgray, next_rbin, next_rgray;
   logic push, pop;

   acsp_sync #(.WIDTH(AW + 1)) u_sync_r2w (
      .clk(wr_clk),
      .din(rgray),
      .dout(wq_rgray)
   );
   acsp_sync #(.WIDTH(AW + 1)) u_sync_w2r (
      .clk(rd_clk),
      .din(wgray),
      .dout(rq_wgray)
   );

   // ============================================================
   // Write side
   assign push = wr_valid & wr_ready;
   assign next_wbin = wbin + (AW + 1)'(push);
   assign next_wgray = (next_wbin >> 1) ^ next_wbin;

   always_ff @(posedge wr_clk) begin
      if (push) begin
         mem[wbin[AW-1:0]] <= wr_data;
      end
   end

   // Full is registered so the source sees an honest ready from a flop
   always_ff @(posedge wr_clk) begin
      if (wr_rst) begin
         wbin <= '0;
         wgray <= '0;
         wr_ready <= 1'b0;
      end else begin
         wbin <= next_wbin;
         wgray <= next_wgray;
         wr_ready <= next_wgray !=
            {~wq_rgray[AW:AW-1], wq_rgray[AW-2:0]};
      end
   end

   // ============================================================
   // Read side
   assign pop = rd_valid & rd_ready;
   assign next_rbin = rbin + (AW + 1)'(pop);
   assign next_rgray = (next_rbin >> 1) ^ next_rbin;
   assign rd_data = mem[rbin[AW-1:0]];

   always_ff @(posedge rd_clk) begin
      if (rd_rst) begin
         rbin <= '0;
         rgray <= '0;
         rd_valid <= 1'b0;
      end else begin
         rbin <= next_rbin;
         rgray <= next_rgray;
         rd_valid <= next_rgray != rq_wgray;
      end
   end
endmodule : acsp_fifo
`default_nettype wire

// [design/acsp_stream_port.sv]
// Behaviour
// - One byte per transfer on an eight-line two-way bus, bit 7 MSB.
// - All port signals except frame sync in and out sampled and driven on codec port clock rising edge.
// - Start marker only asserted together with the byte valid qualifier.
// - Frame sync input captures a timestamp into SYT of transmit quadlet two.
// - Frame sync output derives from SYT of receive header quadlet two.
// - Valid qualifier high exactly in cycles where the bus holds a byte.
// - CRC fault output high while delivering bytes of a CRC-failed packet.
// - Sequence fault output high when source packets were lost before byte.
// - Start marker lasts one clock, aligned with the packet's first byte.
// - Half-duplex: either transmit or receive at any time, never both.
// - Stamped SYT equals capture time plus three 125 us bus cycles.
// - Frame sync output pulses when received SYT matches the cycle timer.
`timescale 1ns/1ps
`default_nettype none
module acsp_stream_port #(
   parameter int DEPTH = acsp_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic tx_mode,
   input wire logic [acsp_pkg::QUAD_W-1:0] cycle_timer,
   input wire logic codec_port_clock,
   input wire logic [acsp_pkg::BYTE_W-1:0] codec_byte_bus_in,
   output logic [acsp_pkg::BYTE_W-1:0] codec_byte_bus_out,
   output logic codec_byte_bus_oe,
   input wire logic byte_valid_qualifier_in,
   output logic byte_valid_qualifier_out,
   output logic byte_valid_qualifier_oe,
   input wire logic packet_start_marker_in,
   output logic packet_start_marker_out,
   output logic packet_start_marker_oe,
   input wire logic packet_end_marker,
   output logic crc_fault_output,
   output logic sequence_fault_output,
   input wire logic frame_sync_input,
   output logic frame_sync_output,
   input wire logic [acsp_pkg::SYT_W-1:0] tx_header_upper,
   output logic [acsp_pkg::QUAD_W-1:0] tx_header_quadlet_two,
   input wire logic [acsp_pkg::QUAD_W-1:0] rx_header_quadlet_two,
   input wire logic rx_header_load,
   output logic [acsp_pkg::BYTE_W-1:0] tx_out_data,
   output logic tx_out_start,
   output logic tx_out_end,
   output logic tx_out_valid,
   input wire logic tx_out_ready,
   input wire logic [acsp_pkg::BYTE_W-1:0] rx_in_data,
   input wire logic rx_in_start,
   input wire logic rx_in_crc_err,
   input wire logic rx_in_seq_err,
   input wire logic rx_in_valid,
   output logic rx_in_ready
);
   localparam int WW = acsp_pkg::WORD_W;
   localparam int BW = acsp_pkg::BYTE_W;
   localparam int SW = acsp_pkg::SYT_W;

   // ============================================================
   // Crossings into the link domain, and frame sync into the system domain
   logic link_rst;
   logic tx_mode_l;
   logic fsync_s;

   acsp_sync #(.WIDTH(1)) u_sync_rst (
      .clk(codec_port_clock),
      .din(srst),
      .dout(link_rst)
   );
   acsp_sync #(.WIDTH(1)) u_sync_mode (
      .clk(codec_port_clock),
      .din(tx_mode),
      .dout(tx_mode_l)
   );
   // Frame sync timing is unrelated to the codec clock
   acsp_sync #(.WIDTH(1)) u_sync_fsync (
      .clk(clk),
      .din(frame_sync_input),
      .dout(fsync_s)
   );

   // ============================================================
   // Transmit capture, link domain
   logic [BW-1:0] cap_data;
   logic cap_valid, cap_start, cap_end;
   logic tx_push, tx_wr_ready;
   logic [WW-1:0] tx_wr_data;

   always_ff @(posedge codec_port_clock) begin
      if (link_rst) begin
         cap_data <= '0;
         cap_valid <= 1'b0;
         cap_start <= 1'b0;
         cap_end <= 1'b0;
      end else begin
         cap_data <= codec_byte_bus_in;
         cap_valid <= byte_valid_qualifier_in & tx_mode_l;
         cap_start <= packet_start_marker_in & byte_valid_qualifier_in;
         cap_end <= packet_end_marker & byte_valid_qualifier_in;
      end
   end

   // transmit path only in transmit mode
   assign tx_push = cap_valid & tx_mode_l & tx_wr_ready;
   // The codec has no ready pin, so a byte arriving on a full FIFO is lost
   assign tx_wr_data = {1'b0, cap_end, cap_start, cap_data};

   logic tx_rd_valid, tx_pop;
   logic [WW-1:0] tx_rd_data;

   acsp_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) u_tx_fifo (
      .wr_clk(codec_port_clock),
      .wr_rst(link_rst),
      .wr_valid(tx_push),
      .wr_data(tx_wr_data),
      .wr_ready(tx_wr_ready),
      .rd_clk(clk),
      .rd_rst(srst),
      .rd_valid(tx_rd_valid),
      .rd_data(tx_rd_data),
      .rd_ready(tx_pop)
   );

   // ============================================================
   // Transmit output stage, system domain
   assign tx_pop = tx_rd_valid & (~tx_out_valid | tx_out_ready);

   always_ff @(posedge clk) begin
      if (srst) begin
         tx_out_valid <= 1'b0;
         tx_out_data <= '0;
         tx_out_start <= 1'b0;
         tx_out_end <= 1'b0;
      end else if (~tx_out_valid | tx_out_ready) begin
         tx_out_valid <= tx_rd_valid;
         tx_out_data <= tx_rd_data[BW-1:0];
         tx_out_start <= tx_rd_data[acsp_pkg::W_START];
         tx_out_end <= tx_rd_data[acsp_pkg::W_END];
      end
   end

   // ============================================================
   // Receive path into the link domain
   logic rx_rd_valid, rx_pop;
   logic [WW-1:0] rx_rd_data;
   logic [WW-1:0] rx_wr_data;

   assign rx_wr_data = {rx_in_seq_err, rx_in_crc_err, rx_in_start,
                        rx_in_data};

   acsp_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) u_rx_fifo (
      .wr_clk(clk),
      .wr_rst(srst),
      .wr_valid(rx_in_valid),
      .wr_data(rx_wr_data),
      .wr_ready(rx_in_ready),
      .rd_clk(codec_port_clock),
      .rd_rst(link_rst),
      .rd_valid(rx_rd_valid),
      .rd_data(rx_rd_data),
      .rd_ready(rx_pop)
   );

   assign rx_pop = rx_rd_valid & ~tx_mode_l;

   always_ff @(posedge codec_port_clock) begin
      if (link_rst) begin
         codec_byte_bus_out <= '0;
         byte_valid_qualifier_out <= 1'b0;
         packet_start_marker_out <= 1'b0;
      end else begin
         codec_byte_bus_out <= rx_pop ? rx_rd_data[BW-1:0] : '0;
         byte_valid_qualifier_out <= rx_pop;
         packet_start_marker_out <= rx_pop & rx_rd_data[acsp_pkg::W_START];
      end
   end

   always_ff @(posedge codec_port_clock) begin
      if (link_rst) begin
         crc_fault_output <= 1'b0;
      end else begin
         crc_fault_output <= rx_pop & rx_rd_data[acsp_pkg::W_CRC];
      end
   end

   always_ff @(posedge codec_port_clock) begin
      if (link_rst) begin
         sequence_fault_output <= 1'b0;
      end else begin
         sequence_fault_output <= rx_pop & rx_rd_data[acsp_pkg::W_SEQ];
      end
   end

   always_ff @(posedge codec_port_clock) begin
      if (link_rst) begin
         codec_byte_bus_oe <= 1'b0;
         byte_valid_qualifier_oe <= 1'b0;
         packet_start_marker_oe <= 1'b0;
      end else begin
         codec_byte_bus_oe <= ~tx_mode_l;
         byte_valid_qualifier_oe <= ~tx_mode_l;
         packet_start_marker_oe <= ~tx_mode_l;
      end
   end

   // ============================================================
   // Frame sync timestamping, system domain
   logic fsync_prev, fsync_rise;
   logic [SW-1:0] stamp;

   always_ff @(posedge clk) begin
      if (srst) begin
         fsync_prev <= 1'b0;
      end else begin
         fsync_prev <= fsync_s;
      end
   end
   assign fsync_rise = fsync_s & ~fsync_prev;

   assign stamp = {cycle_timer[SW-1:acsp_pkg::SYT_CYC_LSB] +
                   acsp_pkg::SYT_ADVANCE,
                   cycle_timer[acsp_pkg::SYT_CYC_LSB-1:0]};

   always_ff @(posedge clk) begin
      if (srst) begin
         tx_header_quadlet_two <= '0;
      end else begin
         tx_header_quadlet_two[acsp_pkg::QUAD_W-1:SW] <= tx_header_upper;
         if (fsync_rise) begin
            tx_header_quadlet_two[SW-1:0] <= stamp;
         end
      end
   end

   logic [SW-1:0] rx_syt;
   logic armed, syt_match;

   assign syt_match = armed & (cycle_timer[SW-1:0] == rx_syt);

   // arm from receive quadlet; load wins over match
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_syt <= '0;
         armed <= 1'b0;
      end else if (rx_header_load) begin
         rx_syt <= rx_header_quadlet_two[SW-1:0];
         armed <= 1'b1;
      end else if (syt_match) begin
         armed <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         frame_sync_output <= 1'b0;
      end else begin
         frame_sync_output <= syt_match;
      end
   end

   // ============================================================
   // Checks
   sequence s_first_byte;
      rx_pop && rx_rd_data[acsp_pkg::W_START];
   endsequence
   sequence s_pin_byte;
      tx_mode_l && byte_valid_qualifier_in;
   endsequence

   valid_start_a: assert property (
      @(posedge codec_port_clock) disable iff (link_rst)
      packet_start_marker_out |-> byte_valid_qualifier_out)
      else $error("start marker without valid");
   first_byte_a: assert property (
      @(posedge codec_port_clock) disable iff (link_rst)
      s_first_byte |=> packet_start_marker_out && byte_valid_qualifier_out
      && codec_byte_bus_out == $past(rx_rd_data[BW-1:0]))
      else $error("start marker not on first byte");
   valid_exact_a: assert property (
      @(posedge codec_port_clock) disable iff (link_rst)
      !rx_pop |=> !byte_valid_qualifier_out && codec_byte_bus_out == '0)
      else $error("valid without a byte");
   pin_capture_a: assert property (
      @(posedge codec_port_clock) disable iff (link_rst)
      s_pin_byte |=> cap_valid && cap_data == $past(codec_byte_bus_in))
      else $error("codec byte not captured");
   crc_flag_a: assert property (
      @(posedge codec_port_clock) disable iff (link_rst)
      rx_pop |=> crc_fault_output == $past(rx_rd_data[acsp_pkg::W_CRC]))
      else $error("crc fault not with byte");
   seq_flag_a: assert property (
      @(posedge codec_port_clock) disable iff (link_rst)
      rx_pop |=> sequence_fault_output == $past(rx_rd_data[acsp_pkg::W_SEQ]))
      else $error("sequence fault not with byte");
   half_duplex_a: assert property (
      @(posedge codec_port_clock) disable iff (link_rst)
      tx_mode_l |=> !byte_valid_qualifier_out && !(tx_push && rx_pop))
      else $error("both directions active");
   pins_released_a: assert property (
      @(posedge codec_port_clock) disable iff (link_rst)
      tx_mode_l [*2] |-> !codec_byte_bus_oe && !packet_start_marker_oe)
      else $error("pins driven in transmit");
   stamp_value_a: assert property (
      @(posedge clk) disable iff (srst)
      fsync_rise |=> tx_header_quadlet_two[SW-1:0] ==
      {$past(cycle_timer[SW-1:acsp_pkg::SYT_CYC_LSB]) +
      acsp_pkg::SYT_ADVANCE, $past(cycle_timer[acsp_pkg::SYT_CYC_LSB-1:0])})
      else $error("stamp not three cycles ahead");
   stamp_hold_a: assert property (
      @(posedge clk) disable iff (srst)
      !fsync_rise |=> $stable(tx_header_quadlet_two[SW-1:0]))
      else $error("stamp changed without frame sync");
   syt_load_a: assert property (
      @(posedge clk) disable iff (srst)
      rx_header_load |=> armed &&
      rx_syt == $past(rx_header_quadlet_two[SW-1:0]))
      else $error("received SYT not loaded");
   fsync_pulse_a: assert property (
      @(posedge clk) disable iff (srst)
      syt_match && !rx_header_load |=> frame_sync_output && !armed
      ##1 !frame_sync_output)
      else $error("frame sync pulse wrong");
endmodule : acsp_stream_port
`default_nettype wire

// [tb/acsp_codec_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Codec partner: sources bytes in transmit mode, logs them in receive
module acsp_codec_model (
   input wire logic lclk,
   input wire logic [7:0] dev_bus,
   input wire logic dev_oe,
   input wire logic dev_valid,
   input wire logic dev_start,
   input wire logic dev_crc,
   input wire logic dev_seq,
   output logic [7:0] cod_bus,
   output logic cod_valid,
   output logic cod_start,
   output logic cod_end
);
   logic [10:0] rx_q[$];
   int bad = 0;
   logic sending = 1'b0;

   initial begin
      cod_bus = 8'h5a;
      cod_valid = 1'b0;
      cod_start = 1'b0;
      cod_end = 1'b0;
   end

   // Released bus toggles so a stale byte never looks valid
   always @(posedge lclk) begin
      if (!sending)
         cod_bus <= ~cod_bus;
   end

   // ============================================================
   // Source one packet, one byte per link cycle
   task automatic send(input int n, input logic [7:0] base);
      sending = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge lclk);
         cod_bus <= base + 8'(i);
         cod_valid <= 1'b1;
         cod_start <= (i == 0);
         cod_end <= (i == n - 1) && (n % 4 != 0);
      end
      @(posedge lclk);
      cod_valid <= 1'b0;
      cod_start <= 1'b0;
      cod_end <= 1'b0;
      cod_bus <= ~cod_bus;
      sending <= 1'b0;
   endtask : send

   // ============================================================
   // Log delivered bytes with their flags
   always @(posedge lclk) begin
      if (dev_oe && dev_valid)
         rx_q.push_back({dev_seq, dev_crc, dev_start, dev_bus});
      if (dev_oe && dev_start && !dev_valid)
         bad++;
   end
endmodule : acsp_codec_model
`default_nettype wire

// [tb/acsp_stream_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Stream port bench
module acsp_stream_port_tb;
   localparam int DEPTH = 8;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic srst = 1'b1;
   logic tx_mode = 1'b1;
   logic [31:0] cycle_timer = 32'h0000_0000;
   logic fsync_in = 1'b0;
   logic [15:0] hdr_upper = 16'h0000;
   logic [31:0] rx_hdr = 32'h0000_0000;
   logic rx_load = 1'b0;
   logic tx_ready = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic rx_start = 1'b0;
   logic rx_crc = 1'b0;
   logic rx_seq = 1'b0;
   logic rx_valid = 1'b0;
   logic [7:0] bus_out, bus_in, cod_bus, tx_data;
   logic bus_oe, val_out, val_oe, val_in, st_out, st_oe, st_in;
   logic cod_valid, cod_start, cod_end, crc_o, seq_o, fsync_out;
   logic tx_start, tx_end, tx_valid, rx_ready;
   logic [31:0] txq2;
   int num_errors = 0;
   int n_tests = 0;

   always #50 clk = ~clk;
   // Offset keeps the link edges off the system edges
   initial begin
      #1.1;
      forever #3 lclk = ~lclk;
   end

   assign bus_in = bus_oe ? bus_out : cod_bus;
   assign val_in = val_oe ? val_out : cod_valid;
   assign st_in = st_oe ? st_out : cod_start;

   acsp_stream_port #(.DEPTH(DEPTH)) acsp_stream_port_inst (
      .clk(clk), .srst(srst), .tx_mode(tx_mode),
      .cycle_timer(cycle_timer), .codec_port_clock(lclk),
      .codec_byte_bus_in(bus_in), .codec_byte_bus_out(bus_out),
      .codec_byte_bus_oe(bus_oe), .byte_valid_qualifier_in(val_in),
      .byte_valid_qualifier_out(val_out),
      .byte_valid_qualifier_oe(val_oe), .packet_start_marker_in(st_in),
      .packet_start_marker_out(st_out), .packet_start_marker_oe(st_oe),
      .packet_end_marker(cod_end), .crc_fault_output(crc_o),
      .sequence_fault_output(seq_o), .frame_sync_input(fsync_in),
      .frame_sync_output(fsync_out), .tx_header_upper(hdr_upper),
      .tx_header_quadlet_two(txq2), .rx_header_quadlet_two(rx_hdr),
      .rx_header_load(rx_load), .tx_out_data(tx_data),
      .tx_out_start(tx_start), .tx_out_end(tx_end),
      .tx_out_valid(tx_valid), .tx_out_ready(tx_ready),
      .rx_in_data(rx_data), .rx_in_start(rx_start),
      .rx_in_crc_err(rx_crc), .rx_in_seq_err(rx_seq),
      .rx_in_valid(rx_valid), .rx_in_ready(rx_ready));

   acsp_codec_model acsp_codec_model_inst (
      .lclk(lclk), .dev_bus(bus_out), .dev_oe(bus_oe),
      .dev_valid(val_out), .dev_start(st_out), .dev_crc(crc_o),
      .dev_seq(seq_o), .cod_bus(cod_bus), .cod_valid(cod_valid),
      .cod_start(cod_start), .cod_end(cod_end));

   // ============================================================
   // Compare and closing tasks
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic close_out;
      $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   // ============================================================
   // Scenarios
   task automatic sc_fill_rx;
      int acc;
      int k;
      logic [10:0] ex;
      acc = 0;
      k = 0;
      rx_valid <= 1'b1;
      rx_data <= 8'h40;
      rx_start <= 1'b1;
      rx_crc <= 1'b0;
      rx_seq <= 1'b0;
      repeat (12) begin
         @(posedge clk);
         if (rx_ready === 1'b1)
            acc++;
         rx_data <= 8'h40 + 8'(acc);
         rx_start <= (acc == 0);
         rx_crc <= acc[0];
         rx_seq <= acc[1];
      end
      rx_valid <= 1'b0;
      @(posedge clk);
      chk_word(acc, DEPTH);
      chk_bit(rx_ready, 1'b0);
      chk_word({bus_oe, val_oe, st_oe}, 32'h0000_0000);
      chk_word(acsp_codec_model_inst.rx_q.size(), 0);
      tx_mode <= 1'b0;
      while (acsp_codec_model_inst.rx_q.size() < 8 && k < 60) begin
         @(posedge clk);
         k++;
      end
      chk_word(acsp_codec_model_inst.rx_q.size(), 8);
      chk_word({bus_oe, val_oe, st_oe}, 32'h0000_0007);
      for (int i = 0; i < 8; i++) begin
         ex = {i[1], i[0], i == 0, 8'h40 + 8'(i)};
         chk_word(acsp_codec_model_inst.rx_q[i], ex);
      end
      // Read pointer needs two system flops and the ready flop to come back
      repeat (3) @(posedge clk);
      chk_bit(rx_ready, 1'b1);
      $display("done fill and receive");
   endtask : sc_fill_rx

   task automatic get_tx(input logic [7:0] d, input logic s, input logic e);
      int k;
      k = 0;
      @(posedge clk);
      while (tx_valid !== 1'b1 && k < 40) begin
         @(posedge clk);
         k++;
      end
      repeat (2) @(posedge clk);
      chk_bit(tx_valid, 1'b1);
      chk_word({tx_end, tx_start, tx_data}, {e, s, d});
      tx_ready <= 1'b1;
      @(posedge clk);
      tx_ready <= 1'b0;
   endtask : get_tx

   task automatic sc_tx(input int n, input logic [7:0] base);
      tx_mode <= 1'b1;
      repeat (3) @(posedge clk);
      fork
         acsp_codec_model_inst.send(n, base);
         for (int i = 0; i < n; i++)
            get_tx(base + 8'(i), i == 0, (i == n - 1) && (n % 4 != 0));
      join
      chk_word({bus_oe, val_oe, st_oe}, 32'h0000_0000);
      $display("done transmit of %0d bytes", n);
   endtask : sc_tx

   task automatic sc_fsync(input logic [31:0] ct, input logic [15:0] syt);
      hdr_upper <= ~syt;
      cycle_timer <= ct;
      @(posedge clk);
      fsync_in <= 1'b1;
      repeat (6) @(posedge clk);
      chk_word(txq2, {~syt, syt});
      fsync_in <= 1'b0;
      repeat (3) @(posedge clk);
      $display("done frame sync stamp");
   endtask : sc_fsync

   task automatic sc_match;
      int pulses;
      pulses = 0;
      cycle_timer <= 32'h0000_0000;
      rx_hdr <= 32'h0000_2456;
      rx_load <= 1'b1;
      @(posedge clk);
      rx_load <= 1'b0;
      repeat (4) begin
         @(posedge clk);
         if (fsync_out === 1'b1)
            pulses++;
      end
      chk_word(pulses, 0);
      // Match held on purpose: only one pulse may follow one load
      cycle_timer <= 32'h0001_2456;
      repeat (8) begin
         @(posedge clk);
         if (fsync_out === 1'b1)
            pulses++;
      end
      chk_word(pulses, 1);
      $display("done frame sync match");
   endtask : sc_match

   // ============================================================
   // Main sequence and watchdog
   initial begin
      int k;
      k = 0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      while (rx_ready !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      repeat (2) @(posedge clk);
      chk_bit(tx_valid, 1'b0);
      sc_fill_rx();
      sc_tx(5, 8'ha0);
      sc_tx(4, 8'hb0);
      sc_fsync(32'h0000_e123, 16'h1123);
      sc_fsync(32'h0000_5abc, 16'h8abc);
      sc_match();
      chk_word(acsp_codec_model_inst.bad, 0);
      close_out();
   end

   initial begin
      #2_000_000;
      num_errors++;
      close_out();
   end
endmodule : acsp_stream_port_tb
`default_nettype wire
